// ### inc/gwb_pkg.sv
package gwb_pkg;

  // Core clock frequency in Hz and period in ns.
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_NS        = 100;

  // Wake hold time in ms and the derived least count of cycles.
  localparam int unsigned WAKE_HOLD_MS  = 10;
  localparam int unsigned WAKE_HOLD_CYC = (WAKE_HOLD_MS * 1_000_000 + CLK_NS - 1) / CLK_NS;

  // Startup strap window in ms and its count of cycles.
  localparam int unsigned BOOT_WIN_MS   = 50;
  localparam int unsigned BOOT_WIN_CYC  = (BOOT_WIN_MS * 1_000_000 + CLK_NS - 1) / CLK_NS;

  // One second of cycles and the timing pulse width.
  localparam int unsigned PPS_PERIOD_MS = 1000;
  localparam int unsigned PPS_PERIOD_CYC = (PPS_PERIOD_MS / 1000) * CLK_HZ;
  localparam int unsigned PPS_HIGH_MS   = 100;
  localparam int unsigned PPS_HIGH_CYC  = (PPS_HIGH_MS * 1_000_000) / CLK_NS;

  typedef enum logic [1:0] {
    GWB_ST_STARTUP,
    GWB_ST_RUN,
    GWB_ST_STANDBY,
    GWB_ST_BOOTDL
  } gwb_state_t;

  // Standby request from the command decoder.
  typedef struct packed {
    logic        req;
    logic        timed;
    logic [31:0] cycles;
  } gwb_stby_cmd_t;

endpackage

// ### rtl/gwb_pps_gen.sv
`timescale 1ns/1ps
`default_nettype none
module gwb_pps_gen #(
  parameter int unsigned PERIOD = gwb_pkg::PPS_PERIOD_CYC,
  parameter int unsigned HIGH   = gwb_pkg::PPS_HIGH_CYC
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      pulse_q
);
  import gwb_pkg::*;

  logic [31:0] cnt_q;
  wire         wrap  = (cnt_q == 32'(PERIOD - 1));
  wire  [31:0] cnt_d = !run ? 32'(PERIOD - 1) : (wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001);

  // Idle parks the count on its last value, so the first running cycle wraps at once.
  // Every rising edge, the first one too, then marks a full second.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= 32'(PERIOD - 1);
      pulse_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pulse_q <= run && (cnt_d < 32'(HIGH)); // [R5]
    end
  end

  pps_period_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
    $rose(pulse_q) |-> $past(cnt_q) == 32'(PERIOD - 1))
    else $error("Timing pulse rose away from a second boundary.");
  pps_width_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
    $fell(pulse_q) |-> $past(cnt_q) == 32'(HIGH - 1) || !$past(run))
    else $error("Timing pulse ended early.");
endmodule
`default_nettype wire

// ### rtl/gwb_wake_boot.sv
// Functional notes
// R1: Wake held high 10 ms leaves standby.
// R2: Host keeps wake low while running.
// R3: Boot strap high 50 ms selects download.
// R4: Undriven boot strap reads low, normal start.
// R5: One timing pulse per second, rising edge.
// R6: Host keeps timing pulse low at startup.
// R7: RF supply off in backup mode.
// R8: Warning output driven only with valid supply.
// R9: Standby by command; exit wake or timeout.
// R10: Wake must be low when standby commanded.
// R11: Reset low holds; release restarts with strap.
`timescale 1ns/1ps
`default_nettype none
module gwb_wake_boot #(
  parameter int unsigned WAKE_CYC   = gwb_pkg::WAKE_HOLD_CYC,
  parameter int unsigned BOOT_CYC   = gwb_pkg::BOOT_WIN_CYC,
  parameter int unsigned PPS_PERIOD = gwb_pkg::PPS_PERIOD_CYC,
  parameter int unsigned PPS_HIGH   = gwb_pkg::PPS_HIGH_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   standby_wake_input,
  input  wire logic                   boot_select,
  input  wire logic                   main_supply_ok,
  input  wire logic                   backup_mode,
  input  wire logic                   warning_event,
  input  wire gwb_pkg::gwb_stby_cmd_t forced_standby_command,
  output logic                        second_timing_pulse,
  output logic                        rf_supply_output,
  output logic                        warning_indicator_out,
  output logic                        warning_indicator_oe,
  output logic                        boot_download_mode,
  output logic                        standby_active
);
  import gwb_pkg::*;

  gwb_state_t  state_q;
  gwb_state_t  state_d;
  logic [31:0] wake_cnt_q;
  logic [31:0] boot_cnt_q;
  logic [31:0] win_cnt_q;
  logic [31:0] stby_cnt_q;
  logic        stby_timed_q;
  logic        boot_seen_q;
  logic        pps_pulse;

  // A floating strap is modelled as low by the internal pull-down.
  wire boot_hi      = (boot_select === 1'b1); // [R4]
  wire win_done     = (win_cnt_q == 32'(BOOT_CYC - 1));
  wire boot_hit     = boot_seen_q || (boot_cnt_q == 32'(BOOT_CYC - 1) && boot_hi);
  wire wake_done    = (wake_cnt_q == 32'(WAKE_CYC - 1)) && standby_wake_input;
  wire stby_expired = stby_timed_q && (stby_cnt_q == 32'h0000_0001);
  wire stby_go      = forced_standby_command.req && !standby_wake_input; // [R10]
  wire running      = (state_q == GWB_ST_RUN);

  // Download mode is left only through reset; standby only by wake or its own timer.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      GWB_ST_STARTUP: begin
        if (win_done) begin
          state_d = boot_hit ? GWB_ST_BOOTDL : GWB_ST_RUN; // [R3] [R11]
        end
      end
      GWB_ST_RUN: begin
        if (stby_go) begin
          state_d = GWB_ST_STANDBY; // [R9]
        end
      end
      GWB_ST_STANDBY: begin
        if (wake_done || stby_expired) begin
          state_d = GWB_ST_RUN; // [R1] [R9]
        end
      end
      GWB_ST_BOOTDL: begin
        state_d = GWB_ST_BOOTDL;
      end
    endcase
  end

  // Reset holds the startup state; release reruns the strap window.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= GWB_ST_STARTUP; // [R11]
    end else begin
      state_q <= state_d;
    end
  end

  // Strap window: the strap must be high for the whole window to select download.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      win_cnt_q   <= 32'h0000_0000;
      boot_cnt_q  <= 32'h0000_0000;
      boot_seen_q <= 1'b0;
    end else if (state_q == GWB_ST_STARTUP) begin
      win_cnt_q   <= win_cnt_q + 32'h0000_0001;
      boot_cnt_q  <= boot_hi ? boot_cnt_q + 32'h0000_0001 : 32'h0000_0000; // [R3]
      boot_seen_q <= boot_hit;
    end
  end

  // Wake hold counter: counts consecutive high cycles in standby only.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_cnt_q <= 32'h0000_0000;
    end else if (state_q == GWB_ST_STANDBY && standby_wake_input && !wake_done) begin
      wake_cnt_q <= wake_cnt_q + 32'h0000_0001; // [R1]
    end else begin
      wake_cnt_q <= 32'h0000_0000;
    end
  end

  // Standby duration from the command; zero means wait for wake only.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stby_cnt_q   <= 32'h0000_0000;
      stby_timed_q <= 1'b0;
    end else if (running && stby_go) begin
      stby_cnt_q   <= forced_standby_command.cycles;
      stby_timed_q <= forced_standby_command.timed && (forced_standby_command.cycles != 32'h0);
    end else if (state_q == GWB_ST_STANDBY && stby_cnt_q != 32'h0000_0000) begin
      stby_cnt_q   <= stby_cnt_q - 32'h0000_0001; // [R9]
    end
  end

  // The pulse generator counts only in normal operation; standby and download keep it low.
  gwb_pps_gen #(
    .PERIOD (PPS_PERIOD),
    .HIGH   (PPS_HIGH)
  ) gwb_pps_gen_i (
    .core_clk (core_clk),
    .nrst     (nrst),
    .run      (running),
    .pulse_q  (pps_pulse)
  );

  // Outputs are all registered.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      second_timing_pulse   <= 1'b0;
      rf_supply_output      <= 1'b0;
      warning_indicator_out <= 1'b0;
      warning_indicator_oe  <= 1'b0;
      boot_download_mode    <= 1'b0;
      standby_active        <= 1'b0;
    end else begin
      second_timing_pulse   <= pps_pulse; // [R5]
      rf_supply_output      <= main_supply_ok && !backup_mode; // [R7]
      warning_indicator_out <= main_supply_ok && warning_event; // [R8]
      warning_indicator_oe  <= main_supply_ok; // [R8]
      boot_download_mode    <= (state_q == GWB_ST_BOOTDL); // [R3]
      standby_active        <= (state_q == GWB_ST_STANDBY);
    end
  end

  wake_exit_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
    (state_q == GWB_ST_STANDBY && wake_done) |=> state_q == GWB_ST_RUN)
    else $error("Held wake did not leave standby.");
  wake_short_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
    (state_q == GWB_ST_STANDBY && !standby_wake_input && !stby_expired)
      |=> state_q == GWB_ST_STANDBY)
    else $error("Standby left without wake or timeout.");
  boot_sel_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R3]
    (state_q == GWB_ST_STARTUP && win_done && boot_hit) |=> state_q == GWB_ST_BOOTDL)
    else $error("Strap high did not select download.");
  boot_low_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R4]
    (state_q == GWB_ST_STARTUP && win_done && !boot_hit) |=> state_q == GWB_ST_RUN)
    else $error("Low strap did not start normal mode.");
  pps_idle_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
    (state_q != GWB_ST_RUN) |-> ##2 !second_timing_pulse || $past(running, 2))
    else $error("Timing pulse outside normal operation.");
  rf_off_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R7]
    backup_mode |=> !rf_supply_output)
    else $error("RF supply on in backup mode.");
  warn_supply_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R8]
    !main_supply_ok |=> !warning_indicator_oe && !warning_indicator_out)
    else $error("Warning driven without valid supply.");
  stby_enter_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R10]
    (running && forced_standby_command.req && standby_wake_input) |=> state_q == GWB_ST_RUN)
    else $error("Standby entered with wake high.");
  stby_time_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R9]
    (state_q == GWB_ST_STANDBY && stby_expired) |=> state_q == GWB_ST_RUN)
    else $error("Standby timeout did not resume operation.");
  rst_restart_a: assert property (@(posedge core_clk) // [R11]
    $rose(nrst) |-> state_q == GWB_ST_STARTUP)
    else $error("Reset release not in startup.");

  // The startup window runs in full and download mode holds until reset.
  start_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R11]
    (state_q == GWB_ST_STARTUP && !win_done) |=> state_q == GWB_ST_STARTUP)
    else $error("Startup window cut short.");
  boot_stay_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R3]
    boot_download_mode |=> boot_download_mode)
    else $error("Download mode left without reset.");
  boot_late_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R3]
    (state_q == GWB_ST_RUN || state_q == GWB_ST_STANDBY) |=> state_q != GWB_ST_BOOTDL)
    else $error("Strap acted after the startup window.");

  // Standby starts only on a command and ends only on a full wake hold or its timer.
  stby_req_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R9]
    (state_q == GWB_ST_RUN && !forced_standby_command.req) |=> state_q != GWB_ST_STANDBY)
    else $error("Standby entered without a command.");
  stby_flag_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R9]
    (state_q == GWB_ST_STANDBY) |=> standby_active)
    else $error("Standby not reported.");
  wake_early_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
    (state_q == GWB_ST_STANDBY && wake_cnt_q != 32'(WAKE_CYC - 1) && !stby_expired)
      |=> state_q == GWB_ST_STANDBY)
    else $error("Standby left before the wake hold time.");

  // The timing pulse only follows normal operation, two cycles late.
  pps_run_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
    second_timing_pulse |-> $past(running, 2))
    else $error("Timing pulse without normal operation.");

  // The supply and warning outputs follow valid inputs one cycle late.
  rf_on_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R7]
    (main_supply_ok && !backup_mode) |=> rf_supply_output)
    else $error("RF supply off outside backup mode.");
  warn_drive_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R8]
    (main_supply_ok && warning_event) |=> warning_indicator_oe && warning_indicator_out)
    else $error("Warning not driven with valid supply.");
endmodule
`default_nettype wire

// ### sim/gwb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gwb_host_model #(
  parameter int unsigned WAKE_CYC = 8
) (
  input  wire logic             core_clk,
  input  wire logic             standby_active,
  input  wire logic             wake_go,
  input  wire logic             stby_go,
  input  wire logic             stby_timed,
  input  wire logic [31:0]      stby_cycles,
  output logic                  standby_wake_input,
  output gwb_pkg::gwb_stby_cmd_t forced_standby_command
);
  import gwb_pkg::*;

  int unsigned hold_q = 0;
  // The host leaves the timing pulse line alone, so it stays low through startup.
  initial begin
    standby_wake_input = 1'b0;
    forced_standby_command = '0;
  end
  // The command is only sent with the wake line low.
  always @(posedge core_clk) begin
    forced_standby_command.req    <= stby_go && !standby_wake_input;
    forced_standby_command.timed  <= stby_timed;
    forced_standby_command.cycles <= stby_cycles;
  end
  // Wake is raised only in standby, for exactly the hold time, so it is low again
  // by the first cycle of normal operation.
  always @(posedge core_clk) begin
    if (wake_go && standby_active) begin
      hold_q <= WAKE_CYC;
    end else if (hold_q != 0) begin
      hold_q <= hold_q - 1;
    end
    standby_wake_input <= (wake_go && standby_active) || hold_q > 1;
  end
endmodule
`default_nettype wire

// ### sim/tb_gwb_wake_boot.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %b want %b", $time, a, b); end end
module tb_gwb_wake_boot;
  import gwb_pkg::*;
  localparam int WAKE = 8;
  localparam int BOOT = 16;
  localparam int PER  = 50;
  localparam int HIGH = 5;
  logic core_clk = 0, nrst = 0, strap = 0, ok = 1, bkp = 0, wev = 0;
  logic wake_go = 0, stby_go = 0, stby_timed = 0;
  logic [31:0] stby_cycles = '0;
  wire logic wake, pps, rf, wout, woe, dl, stby;
  gwb_stby_cmd_t cmd;
  int failures = 0;
  int checks_done = 0;
  always #50 core_clk = ~core_clk;
  gwb_host_model #(.WAKE_CYC(WAKE)) gwb_host_model_i (.core_clk(core_clk),
    .standby_active(stby), .wake_go(wake_go), .stby_go(stby_go), .stby_timed(stby_timed),
    .stby_cycles(stby_cycles), .standby_wake_input(wake), .forced_standby_command(cmd));
  gwb_wake_boot #(.WAKE_CYC(WAKE), .BOOT_CYC(BOOT), .PPS_PERIOD(PER), .PPS_HIGH(HIGH))
    gwb_wake_boot_i (.core_clk(core_clk), .nrst(nrst), .standby_wake_input(wake),
    .boot_select(strap), .main_supply_ok(ok), .backup_mode(bkp), .warning_event(wev),
    .forced_standby_command(cmd), .second_timing_pulse(pps), .rf_supply_output(rf),
    .warning_indicator_out(wout), .warning_indicator_oe(woe), .boot_download_mode(dl),
    .standby_active(stby));
  task automatic rst(input logic s);
    @(posedge core_clk) nrst <= 1'b0;
    strap <= s;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK(pps, 1'b0)
    repeat (BOOT + 2) @(negedge core_clk);
  endtask
  task automatic stby_cmd(input logic t, input int c);
    @(posedge core_clk) stby_go <= 1'b1;
    stby_timed <= t;
    stby_cycles <= c;
    @(posedge core_clk) stby_go <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic t_boot;
    rst(1'b1);
    `CHK(dl, 1'b1)
    stby_cmd(1'b0, 0);
    `CHK(stby, 1'b0)
    rst(1'bz);
    `CHK(dl, 1'b0)
  endtask
  task automatic t_pps;
    int n;
    n = 0;
    while (pps === 1'b1 && n < 2 * PER) begin @(negedge core_clk); n++; end
    n = 0;
    while (pps !== 1'b1 && n < 2 * PER) begin @(negedge core_clk); n++; end
    `CHK(pps, 1'b1)
    n = 0;
    while (pps === 1'b1 && n < PER) begin @(negedge core_clk); n++; end
    `CHK(n, HIGH)
    while (pps !== 1'b1 && n < 2 * PER) begin @(negedge core_clk); n++; end
    `CHK(n, PER)
  endtask
  task automatic t_supply;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk) ok <= i[1];
      bkp <= i[0];
      wev <= i[2];
      repeat (2) @(negedge core_clk);
      `CHK(rf, i[1] & ~i[0])
      `CHK(woe, i[1])
      `CHK(wout, i[1] & i[2])
    end
    @(posedge core_clk) ok <= 1'b1;
    bkp <= 1'b0;
  endtask
  task automatic t_standby;
    int n;
    stby_cmd(1'b0, 0);
    `CHK(stby, 1'b1)
    @(negedge core_clk);
    `CHK(pps, 1'b0)
    @(posedge core_clk) wake_go <= 1'b1;
    @(posedge core_clk) wake_go <= 1'b0;
    n = 1;
    while (stby === 1'b1 && n < 4 * WAKE) begin @(negedge core_clk); n++; end
    `CHK(stby, 1'b0)
    `CHK(n, WAKE + 3)
    stby_cmd(1'b1, 20);
    `CHK(stby, 1'b1)
    n = 3;
    while (stby === 1'b1 && n < 60) begin @(negedge core_clk); n++; end
    `CHK(n, 20 + 3)
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #(5000 * 100);
    failures++;
    stop_test();
  end
  initial begin
    t_boot();
    t_pps();
    t_supply();
    t_standby();
    stop_test();
  end
endmodule
`default_nettype wire
